// ---- rtl/serial_ctrl_pkg.sv ----
// Purpose: Constants shared by the serial control register block
// Assumes: Byte-wide CPU register port, one clock domain
// Notes: Offsets are register indices on the block's local select
`default_nettype none
package serial_ctrl_pkg;
   // Register indices on the local register port
   localparam logic [1:0] CTRL_ONE_IDX = 2'h0;
   localparam logic [1:0] CTRL_TWO_IDX = 2'h1;
   localparam logic [1:0] CTRL_THREE_IDX = 2'h2;
   // Control one field positions
   localparam int MOD_EN_POS = 6;
   localparam int LEN9_POS = 4;
   localparam int WAKE_SEL_POS = 3;
   localparam int PAR_EN_POS = 1;
   localparam int PAR_ODD_POS = 0;
   // Control two field positions
   localparam int TXE_IE_POS = 7;
   localparam int TXD_IE_POS = 6;
   localparam int RXF_IE_POS = 5;
   localparam int IDLE_IE_POS = 4;
   localparam int TX_EN_POS = 3;
   localparam int RX_EN_POS = 2;
   localparam int STBY_POS = 1;
   localparam int BRK_POS = 0;
   // Control three field positions
   localparam int RX9_POS = 7;
   localparam int TX9_POS = 6;
   localparam int OR_IE_POS = 3;
   localparam int NE_IE_POS = 2;
   localparam int FE_IE_POS = 1;
   localparam int PE_IE_POS = 0;
   // Reset values
   localparam logic [7:0] CTRL_RST = 8'h00;
   // Frame lengths in bit times
   localparam logic [3:0] FRAME_SHORT = 4'ha;
   localparam logic [3:0] FRAME_LONG = 4'hb;
   // Default bit period in clock cycles
   localparam int BIT_CYC_DEF = 16;
   // Transmitter states
   typedef enum logic [1:0] {TX_IDLE, TX_PRE, TX_BRK, TX_DATA} tx_state_t;
endpackage
`default_nettype wire

// ---- rtl/serial_ctrl.sv ----
// Purpose: Control registers and transmit sequencing of a serial interface
// Assumes: rx side delivers decoded characters and error flags as pulses/levels
// Notes: Baud divide is a simple fixed bit period parameter
`default_nettype none
module serial_ctrl
   import serial_ctrl_pkg::*;
#(
   parameter int BIT_CYC = BIT_CYC_DEF
)(
   input wire logic clk,
   input wire logic rst,
   input wire logic [1:0] reg_idx,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire logic data_wr,
   input wire logic [7:0] data_wdata,
   input wire logic rx_load,
   input wire logic [8:0] rx_char,
   input wire logic rx_idle_det,
   input wire logic rx_full_flag,
   input wire logic idle_flag,
   input wire logic overrun_flag,
   input wire logic noise_err_flag,
   input wire logic framing_flag,
   input wire logic parity_err_flag,
   output logic tx_line,
   output logic tx_empty_flag,
   output logic tx_done_flag,
   output logic tx_irq,
   output logic rx_irq,
   output logic err_irq,
   output logic rx_active
);
   // Control register storage
   logic [7:0] ctrl_one_r;
   logic [7:0] ctrl_two_r;
   logic [3:0] err_ie_r;
   logic rx_ninth_bit;
   logic tx_ninth_bit;
   // Transmit path state
   tx_state_t tx_state_r;
   logic [7:0] tx_hold_r;
   logic tx_hold_full_r;
   logic [10:0] tx_shift_r;
   logic [3:0] tx_bits_r;
   logic [15:0] baud_r;
   logic idle_pend_r;
   logic brk_seen_r;
   logic brk_mark_r;
   logic tx_en_q_r;
   logic tx_empty_r;
   // Decoded controls
   logic module_en, len9, parity_en, parity_odd_sel, wake_sel;
   logic tx_en, rx_en, rx_standby, send_brk;
   logic bit_tick;
   logic [3:0] frame_len;
   assign module_en = ctrl_one_r[MOD_EN_POS];
   assign len9 = ctrl_one_r[LEN9_POS];
   assign parity_en = ctrl_one_r[PAR_EN_POS];
   assign parity_odd_sel = ctrl_one_r[PAR_ODD_POS];
   assign wake_sel = ctrl_one_r[WAKE_SEL_POS];
   assign tx_en = ctrl_two_r[TX_EN_POS];
   assign rx_en = ctrl_two_r[RX_EN_POS];
   assign rx_standby = ctrl_two_r[STBY_POS];
   assign send_brk = ctrl_two_r[BRK_POS];
   assign bit_tick = (baud_r == 16'(BIT_CYC - 1));
   assign frame_len = len9 ? FRAME_LONG : FRAME_SHORT;

   // Builds a data frame, LSB first after the start bit
   function automatic logic [10:0] build_frame(input logic [7:0] d, input logic b8,
      input logic l9, input logic pe, input logic odd);
      logic par;
      logic [8:0] body;
      par = 1'b0;
      body = 9'h000;
      par = odd ^ (l9 ? ^d : ^d[6:0]);
      if (l9)
      begin
         body = {(pe ? par : b8), d};
      end
      else
      begin
         body = {1'b1, (pe ? par : d[7]), d[6:0]};
      end
      build_frame = {1'b1, body, 1'b0};
   endfunction

   // Control one, read/write
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         ctrl_one_r <= CTRL_RST;
      else if (reg_wr && reg_idx == CTRL_ONE_IDX)
         ctrl_one_r <= reg_wdata;
   end

   // Control two with enable protection and hardware wake clear
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         ctrl_two_r <= CTRL_RST;
      else
      begin
         if (reg_wr && reg_idx == CTRL_TWO_IDX)
         begin
            ctrl_two_r[7:4] <= reg_wdata[7:4];
            ctrl_two_r[1:0] <= reg_wdata[1:0];
            if (module_en)
               ctrl_two_r[3:2] <= reg_wdata[3:2];
         end
         if (rx_standby && rx_load && (wake_sel ? rx_char[len9 ? 8 : 7] : 1'b0))
            ctrl_two_r[STBY_POS] <= 1'b0;
         else if (rx_standby && rx_idle_det && !wake_sel)
            ctrl_two_r[STBY_POS] <= 1'b0;
      end
   end

   // Control three enables; reset clears enables
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         err_ie_r <= 4'h0;
      else if (reg_wr && reg_idx == CTRL_THREE_IDX)
         err_ie_r <= reg_wdata[3:0];
   end

   // Ninth bits have no reset
   // ninth bits untouched by reset
   always_ff @(posedge clk)
   begin
      if (reg_wr && reg_idx == CTRL_THREE_IDX)
         tx_ninth_bit <= reg_wdata[TX9_POS];
      if (rx_load && rx_en)
         rx_ninth_bit <= len9 ? rx_char[8] : rx_char[7];
   end

   // Register read mux
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         reg_rdata <= 8'h00;
      else if (reg_idx == CTRL_ONE_IDX)
         reg_rdata <= ctrl_one_r;
      else if (reg_idx == CTRL_TWO_IDX)
         reg_rdata <= ctrl_two_r;
      else if (reg_idx == CTRL_THREE_IDX)
         reg_rdata <= {rx_ninth_bit, tx_ninth_bit, 2'b00, err_ie_r};
      else
         reg_rdata <= 8'h00;
   end

   // Bit period counter
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         baud_r <= 16'h0000;
      else if (!module_en || bit_tick)
         baud_r <= 16'h0000;
      else
         baud_r <= baud_r + 16'h0001;
   end

   // Data holding register and its empty flag
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         tx_hold_r <= 8'h00;
         tx_hold_full_r <= 1'b0;
      end
      else if (!module_en)
         tx_hold_full_r <= 1'b0;
      else if (data_wr)
      begin
         tx_hold_r <= data_wdata;
         tx_hold_full_r <= 1'b1;
      end
      else if (tx_state_r == TX_IDLE && tx_en && bit_tick && tx_hold_full_r
               && !idle_pend_r && !send_brk && !brk_mark_r)
         tx_hold_full_r <= 1'b0;
   end

   // Enable history, idle queue and break edge tracking
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         tx_en_q_r <= 1'b0;
         idle_pend_r <= 1'b0;
         brk_seen_r <= 1'b0;
      end
      else
      begin
         tx_en_q_r <= tx_en;
         brk_seen_r <= send_brk;
         if (tx_en && !tx_en_q_r)
            idle_pend_r <= 1'b1;
         else if (tx_state_r == TX_IDLE && bit_tick && idle_pend_r)
            idle_pend_r <= 1'b0;
      end
   end

   // Transmit sequencer
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         tx_state_r <= TX_IDLE;
         tx_shift_r <= 11'h7ff;
         tx_bits_r <= 4'h0;
         brk_mark_r <= 1'b0;
      end
      else if (!module_en)
      begin
         tx_state_r <= TX_IDLE;
         tx_shift_r <= 11'h7ff;
         brk_mark_r <= 1'b0;
      end
      else if (bit_tick)
      begin
         case (tx_state_r)
            TX_IDLE:
            begin
               tx_shift_r <= 11'h7ff;
               if (!tx_en)
                  tx_bits_r <= 4'h0;
               else if (send_brk)
               begin
                  tx_state_r <= TX_BRK;
                  tx_shift_r <= 11'h000;
                  tx_bits_r <= frame_len;
                  brk_mark_r <= 1'b1;
               end
               else if (brk_mark_r)
               begin
                  tx_state_r <= TX_PRE;
                  tx_bits_r <= 4'h1;
                  brk_mark_r <= 1'b0;
               end
               else if (idle_pend_r)
               begin
                  tx_state_r <= TX_PRE;
                  tx_bits_r <= frame_len;
               end
               else if (tx_hold_full_r)
               begin
                  tx_state_r <= TX_DATA;
                  tx_shift_r <= build_frame(tx_hold_r, tx_ninth_bit, len9,
                     parity_en, parity_odd_sel);
                  tx_bits_r <= frame_len;
               end
            end
            default:
            begin
               tx_shift_r <= {1'b1, tx_shift_r[10:1]};
               tx_bits_r <= tx_bits_r - 4'h1;
               if (tx_bits_r == 4'h1)
               begin
                  if (tx_state_r == TX_BRK && send_brk && tx_en)
                  begin
                     tx_shift_r <= 11'h000;
                     tx_bits_r <= frame_len;
                  end
                  else
                     tx_state_r <= TX_IDLE;
               end
            end
         endcase
      end
   end

   // Line driver, idles high
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         tx_line <= 1'b1;
      else
         tx_line <= (tx_state_r == TX_IDLE) ? 1'b1 : tx_shift_r[0];
   end

   // Transmit flags
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         tx_empty_r <= 1'b1;
         tx_empty_flag <= 1'b1;
         tx_done_flag <= 1'b1;
      end
      else
      begin
         tx_empty_r <= !module_en || !tx_hold_full_r;
         tx_empty_flag <= !module_en || !tx_hold_full_r;
         tx_done_flag <= !module_en || (!tx_hold_full_r && tx_state_r == TX_IDLE
            && !idle_pend_r && !send_brk && !brk_mark_r);
      end
   end

   // Interrupt requests
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         tx_irq <= 1'b0;
         rx_irq <= 1'b0;
         err_irq <= 1'b0;
         rx_active <= 1'b0;
      end
      else
      begin
         tx_irq <= module_en && ((tx_empty_r && ctrl_two_r[TXE_IE_POS])
            || (tx_done_flag && ctrl_two_r[TXD_IE_POS]));
         rx_irq <= !rx_standby && ((rx_full_flag && ctrl_two_r[RXF_IE_POS])
            || (idle_flag && ctrl_two_r[IDLE_IE_POS]));
         err_irq <= (overrun_flag && err_ie_r[3]) || (noise_err_flag && err_ie_r[2])
            || (framing_flag && err_ie_r[1]) || (parity_err_flag && err_ie_r[0]);
         rx_active <= module_en && rx_en && !rx_standby;
      end
   end
endmodule // serial_ctrl
`default_nettype wire

// ---- verif/serial_ctrl_asserts.sv ----
// Purpose: Port level timing checks for the serial control block
// Assumes: One clock domain, asynchronous active high reset
// Notes: Mirrors the module enable from register writes
`default_nettype none
module serial_ctrl_asserts
   import serial_ctrl_pkg::*;
#(
   parameter int BIT_CYC = BIT_CYC_DEF
)(
   input wire logic clk,
   input wire logic rst,
   input wire logic [1:0] reg_idx,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic rx_full_flag,
   input wire logic idle_flag,
   input wire logic overrun_flag,
   input wire logic noise_err_flag,
   input wire logic framing_flag,
   input wire logic parity_err_flag,
   input wire logic tx_line,
   input wire logic tx_empty_flag,
   input wire logic tx_done_flag,
   input wire logic tx_irq,
   input wire logic rx_irq,
   input wire logic err_irq
);
   logic mod_en_r; // Mirrored module enable
   logic prev_r; // Line level one cycle ago
   logic [7:0] run_r; // Cycles the previous level held
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // Follow the module enable and the line run length
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         mod_en_r <= 1'b0;
         prev_r <= 1'b1;
         run_r <= 8'hff;
      end
      else
      begin
         if (reg_wr && reg_idx == CTRL_ONE_IDX)
            mod_en_r <= reg_wdata[MOD_EN_POS];
         prev_r <= tx_line;
         if (tx_line != prev_r)
            run_r <= 8'h01;
         else if (run_r != 8'hff)
            run_r <= run_r + 8'h01;
      end
   end
   a_bit_hold: assert property ((tx_line != prev_r) |-> run_r >= BIT_CYC)
      else $error("tx bit shorter than one bit period");
   a_reset_vals: assert property ($fell(rst) |-> tx_line && tx_empty_flag && !tx_irq)
      else $error("bad transmit state after reset");
   a_tx_irq_src: assert property (tx_irq |-> tx_empty_flag || tx_done_flag
      || $past(tx_empty_flag || tx_done_flag)) else $error("tx request without flag");
   a_rx_irq_src: assert property (rx_irq |-> $past(rx_full_flag || idle_flag))
      else $error("rx request without flag");
   a_err_irq_src: assert property (err_irq |-> $past(overrun_flag || noise_err_flag
      || framing_flag || parity_err_flag)) else $error("error request without flag");
   a_mod_off: assert property ((!mod_en_r)[*4] |-> tx_empty_flag && tx_done_flag && !tx_irq)
      else $error("module off but tx flags wrong");
   a_idle_high: assert property (tx_done_flag && $past(tx_done_flag) |-> tx_line)
      else $error("line not idle while complete");
   a_busy_low: assert property (!tx_line && !$past(tx_line) |-> !tx_done_flag)
      else $error("complete while line low");
   c_tx_irq: cover property (tx_irq);
   c_brk: cover property ((!tx_line)[*8]);
   c_err: cover property (err_irq);
endmodule // serial_ctrl_asserts
bind serial_ctrl serial_ctrl_asserts #(.BIT_CYC(BIT_CYC)) u_chk (.clk, .rst, .reg_idx,
   .reg_wr, .reg_wdata, .rx_full_flag, .idle_flag, .overrun_flag, .noise_err_flag,
   .framing_flag, .parity_err_flag, .tx_line, .tx_empty_flag, .tx_done_flag, .tx_irq,
   .rx_irq, .err_irq);
`default_nettype wire

// ---- verif/serial_node.sv ----
// Purpose: Remote serial receiver framing the transmit line
// Assumes: Same bit period as the block, LSB first
// Notes: Frame bits beyond the length read high; needs a mark to rearm
`default_nettype none
module serial_node #(
   parameter int BIT_CYC = 4
)(
   input wire logic clk,
   input wire logic rst,
   input wire logic line,
   input wire logic len9,
   output logic [10:0] frame,
   output logic got
);
   logic busy; // Inside a frame
   logic armed; // Mark seen since last frame
   int cnt; // Cycle within bit
   int idx; // Bit index
   // start, payload and stop sampled mid bit
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         {busy, armed, got} <= 3'b000;
         cnt <= 0;
         idx <= 0;
         frame <= '1;
      end
      else if (!busy)
      begin
         got <= 1'b0;
         armed <= armed | line;
         busy <= armed & !line;
         cnt <= 1;
         idx <= 0;
         if (armed & !line)
            frame <= '1;
      end
      else
      begin
         cnt <= (cnt == BIT_CYC - 1) ? 0 : cnt + 1;
         if (cnt == BIT_CYC / 2)
         begin
            frame[idx] <= line;
            idx <= idx + 1;
            // Last bit of the frame ends it
            if (idx == (len9 ? 10 : 9))
               {busy, armed, got} <= 3'b001;
         end
      end
   end
endmodule // serial_node
`default_nettype wire

// ---- verif/test_serial_ctrl.sv ----
// Purpose: Self-checking bench for the serial control block
// Assumes: Short bit period; bench plays the receive front end
// Notes: Seeded random data and interrupt enables; all eight formats in turn
`default_nettype none
module test_serial_ctrl import serial_ctrl_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int BC = 4; // Short bit period
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [1:0] reg_idx = 2'h0;
   logic reg_wr = 1'b0;
   logic data_wr = 1'b0;
   logic rx_load = 1'b0;
   logic rx_idle_det = 1'b0;
   logic len9 = 1'b0;
   logic [7:0] reg_wdata = 8'h00;
   logic [7:0] data_wdata = 8'h00;
   logic [8:0] rx_char = 9'h000;
   logic [5:0] rxf = 6'h00; // Full, idle, overrun, noise, framing, parity
   logic [7:0] reg_rdata;
   logic tx_line, tx_empty_flag, tx_done_flag, tx_irq, rx_irq, err_irq, rx_active, got;
   logic [10:0] frame;
   logic [31:0] r;
   int n_mismatch = 0;
   int compares = 0;
   always #5 clk = ~clk;
   serial_ctrl #(.BIT_CYC(BC)) DUT (.clk, .rst, .reg_idx, .reg_wr, .reg_wdata, .reg_rdata,
      .data_wr, .data_wdata, .rx_load, .rx_char, .rx_idle_det, .rx_full_flag(rxf[5]),
      .idle_flag(rxf[4]), .overrun_flag(rxf[3]), .noise_err_flag(rxf[2]),
      .framing_flag(rxf[1]), .parity_err_flag(rxf[0]), .tx_line, .tx_empty_flag,
      .tx_done_flag, .tx_irq, .rx_irq, .err_irq, .rx_active);
   serial_node #(.BIT_CYC(BC)) u_node (.clk, .rst, .line(tx_line), .len9, .frame, .got);
   task automatic chk(input logic [10:0] g, input logic [10:0] e, input string m);
      compares++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
      end
   endtask
   task automatic print_verdict();
      $display("mismatches %0d compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic wr(input logic [1:0] i, input logic [7:0] v);
      @(posedge clk);
      reg_idx <= i;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [1:0] i, input logic [7:0] e, input logic [7:0] m);
      @(posedge clk);
      reg_idx <= i;
      @(posedge clk);
      #1 chk({3'h0, reg_rdata & m}, {3'h0, e}, "read");
   endtask
   task automatic rxev(input logic ld, input logic [8:0] c);
      @(posedge clk);
      rx_load <= ld;
      rx_idle_det <= !ld;
      rx_char <= c;
      @(posedge clk);
      {rx_load, rx_idle_det} <= 2'b00;
   endtask
   // Wait for a frame (w=0) or transmit complete (w=1)
   task automatic hold(input logic w);
      int k;
      for (k = 0; k < 4000 && !(w ? tx_done_flag : got); k++)
         @(negedge clk);
      if (k == 4000)
      begin
         n_mismatch++;
         $display("[FAIL] %0t wait timed out", $time);
         print_verdict();
      end
   endtask
   // Expected frame, f = {len9, parity on, odd}
   function automatic logic [10:0] fr(input logic [7:0] v, input logic t8, input logic [2:0] f);
      logic p;
      logic [8:0] pl;
      p = (f[2] ? ^v : ^v[6:0]) ^ f[0];
      if (f[1])
         pl = f[2] ? {p, v} : {1'b1, p, v[6:0]};
      else
         pl = f[2] ? {t8, v} : {1'b1, v};
      return {1'b1, pl, 1'b0};
   endfunction
   initial
   begin
      r = $urandom(32'h4117bd44);
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      rd(CTRL_ONE_IDX, 8'h00, 8'hff);
      rd(CTRL_TWO_IDX, 8'h00, 8'hff);
      rd(CTRL_THREE_IDX, 8'h00, 8'h3f);
      rd(2'h3, 8'h00, 8'hff);
      wr(CTRL_TWO_IDX, 8'h0c);
      rd(CTRL_TWO_IDX, 8'h00, 8'hff);
      $display("test reset done");
      wr(CTRL_ONE_IDX, 8'h40);
      wr(CTRL_TWO_IDX, 8'h0c);
      for (int k = 0; k < 8; k++)
      begin
         r = $urandom;
         hold(1'b1);
         len9 <= k[2];
         wr(CTRL_ONE_IDX, {3'h2, k[2], 2'h0, k[1], k[0]});
         wr(CTRL_THREE_IDX, {1'b0, r[8], 6'h00});
         @(posedge clk);
         {data_wr, data_wdata} <= {1'b1, r[7:0]};
         @(posedge clk);
         data_wr <= 1'b0;
         hold(1'b0);
         chk(frame, fr(r[7:0], r[8], k[2:0]), "frame");
      end
      $display("test formats done");
      hold(1'b1);
      wr(CTRL_TWO_IDX, 8'h0d);
      // Hold the break request across at least one bit tick
      repeat (BC) @(posedge clk);
      wr(CTRL_TWO_IDX, 8'h0c);
      hold(1'b0);
      chk(frame, 11'h000, "break");
      $display("test break done");
      // Let the closing mark bit finish before looking at requests
      hold(1'b1);
      for (int k = 0; k < 16; k++)
      begin
         r = $urandom;
         @(posedge clk) rxf <= r[5:0];
         wr(CTRL_TWO_IDX, {r[11:8], 4'hc});
         wr(CTRL_THREE_IDX, {4'h0, r[15:12]});
         repeat (3) @(posedge clk);
         #1 chk(tx_irq, r[11] | r[10], "tx irq");
         chk(rx_irq, r[9] & r[5] | r[8] & r[4], "rx irq");
         chk(err_irq, |(r[15:12] & r[3:0]), "err irq");
      end
      $display("test irq done");
      for (int k = 0; k < 2; k++)
      begin
         r = $urandom;
         wr(CTRL_ONE_IDX, {3'h2, k[0], 4'h0});
         rxev(1'b1, r[8:0]);
         rd(CTRL_THREE_IDX, {k[0] ? r[8] : r[7], 7'h00}, 8'h80);
      end
      $display("test ninth done");
      for (int k = 0; k < 2; k++)
      begin
         wr(CTRL_ONE_IDX, {4'h4, k[0], 3'h0});
         wr(CTRL_TWO_IDX, 8'h2e);
         @(posedge clk) rxf <= 6'h20;
         repeat (3) @(posedge clk);
         #1 chk(rx_irq, 1'b0, "standby irq");
         chk(rx_active, 1'b0, "standby active");
         rxev(k[0], 9'h080);
         rd(CTRL_TWO_IDX, 8'h2c, 8'hff);
         chk(rx_active, 1'b1, "awake active");
      end
      $display("test standby done");
      wr(CTRL_TWO_IDX, 8'hcc);
      wr(CTRL_ONE_IDX, 8'h00);
      repeat (3) @(posedge clk);
      #1 chk({tx_empty_flag, tx_done_flag, tx_irq}, 3'b110, "module off");
      $display("test module off done");
      print_verdict();
   end
endmodule // test_serial_ctrl
`default_nettype wire
